// [logic/reset_source_register_pkg.sv]
// shared constants for the reset source controller and its core-side end
// assumes a 100 MHz system clock; no other dependencies
package reset_cause_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_LOSS_TIME_US = 100;
    localparam int unsigned CLK_LOSS_CYCLES = (CLK_LOSS_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESET_HOLD_CYCLES = 4;
    localparam int unsigned WDT_DIVIDE = 12;
    localparam int unsigned WDT_TIMEOUT_TICKS = 256;

    // reset source register field positions
    localparam int unsigned CLK_LOSS_BIT = 2;
    localparam int unsigned SW_RESET_BIT = 4;
    localparam int unsigned CMP_RESET_BIT = 5;
    localparam int unsigned PM_ERROR_BIT = 6;
    localparam logic [7:0] SRC_RESET_VALUE = 8'h00;

    // top of user code space per variant
    localparam logic [15:0] CODE_TOP_LARGE = 16'h3dff;
    localparam logic [15:0] CODE_TOP_SMALL = 16'h1fff;

    // wishbone register offsets of the core-side end
    localparam logic [7:0] ADR_SOURCE = 8'h00;
    localparam logic [7:0] ADR_CONTROL = 8'h04;
    localparam logic [7:0] ADR_KICK = 8'h08;
    localparam logic [7:0] ADR_ACCESS = 8'h0c;

    // control register fields and values after reset
    localparam int unsigned CTL_STORE_WR_BIT = 0;
    localparam int unsigned CTL_WDT_EN_BIT = 1;
    localparam logic STORE_WR_RESET_VALUE = 1'b0;
    localparam logic WDT_EN_RESET_VALUE = 1'b1;

    // access request register fields
    localparam int unsigned ACC_KIND_LSB = 16;
    localparam int unsigned ACC_DENIED_BIT = 18;
    localparam int unsigned ACC_DEBUG_BIT = 19;

    // index of each cause in the one-hot cause vector
    localparam int unsigned CAUSE_CLK = 0;
    localparam int unsigned CAUSE_CMP = 1;
    localparam int unsigned CAUSE_WDT = 2;
    localparam int unsigned CAUSE_PM = 3;
    localparam int unsigned CAUSE_SW = 4;

    // kinds of program memory access
    typedef enum logic [1:0]
    {
        ACC_DATA_WRITE = 2'h0,
        ACC_ERASE = 2'h1,
        ACC_CODE_READ = 2'h2,
        ACC_FETCH = 2'h3
    } acc_kind_e;

endpackage

// [logic/rst_ctrl_if.sv]
// link between the core-side register end and the reset source controller
// both ends run on the same system clock; no clocking block
`timescale 1ns/100ps
interface rst_ctrl_if;
    import reset_cause_pkg::*;

    logic src_wr;            // one-cycle write of the reset source register
    logic [7:0] src_wdata;
    logic [7:0] src_rdata;   // current reset source register value
    logic sys_reset;         // system reset level
    logic program_store_write_enable; // level: data writes may target program memory
    logic wdt_enable;        // watchdog enable level
    logic wdt_kick;          // one-cycle watchdog service
    logic acc_valid;         // one-cycle program memory access event
    acc_kind_e acc_kind;
    logic [15:0] acc_addr;
    logic acc_denied;        // forbidden by security settings
    logic acc_debug;         // issued through the two wire debug port

    modport device
    (
        input src_wr, src_wdata, program_store_write_enable, wdt_enable, wdt_kick,
        input acc_valid, acc_kind, acc_addr, acc_denied, acc_debug,
        output src_rdata, sys_reset
    );

    modport core
    (
        output src_wr, src_wdata, program_store_write_enable, wdt_enable, wdt_kick,
        output acc_valid, acc_kind, acc_addr, acc_denied, acc_debug,
        input src_rdata, sys_reset
    );

endinterface // rst_ctrl_if

// [logic/reset_source_controller.sv]
// reset source controller: clock loss, comparator, watchdog, program memory
// error and software resets, with the reset source register flags
// assumes clk_i is a free running reference; the monitored clock and the
// comparator output arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - reset when monitored clock stalls over 100 us
// - clock loss flag reads 1 only after that
// - writing bit 2 enables or disables detector
// - internal resets never drive the reset pin
// - writing 1 to bit 5 arms comparator
// - armed comparator low holds device in reset
// - comparator flag reads 1 only after it; the code also sets bit 5 after a watchdog reset
// - software lets comparator settle before arming
// - watchdog enabled after every reset, clock/12
// - watchdog expiry resets and sets its flag
// - enabled data write above code top errors
// - code read above code top errors
// - fetch above code top errors
// - security-forbidden access causes error reset
// - error reset sets flag at bit 6
// - writing 1 to bit 4 forces reset
// - software flag reads 1 after it
// - debug port violations are ignored silently
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module reset_source_controller
#(
    parameter int unsigned CLK_LOSS_LIMIT = reset_cause_pkg::CLK_LOSS_CYCLES,
    parameter int unsigned WDT_TICKS = reset_cause_pkg::WDT_TIMEOUT_TICKS,
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    rst_ctrl_if.device link,
    input wire logic mon_clk_i,
    input wire logic cmp_out_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic sys_reset_o
);
    import reset_cause_pkg::*;

    typedef enum logic
    {
        ST_RUN,
        ST_HOLD
    } state_e;

    localparam logic [15:0] CODE_TOP = LARGE_VARIANT ? CODE_TOP_LARGE : CODE_TOP_SMALL;

    state_e state_r;
    logic [2:0] mon_sync_r;
    logic [1:0] cmp_sync_r;
    logic [31:0] loss_cnt_r;
    logic clk_loss_en_r;
    logic cmp_arm_r;
    logic [3:0] div_cnt_r;
    logic [31:0] wdt_cnt_r;
    logic [31:0] hold_cnt_r;
    logic [4:0] cause_r;
    logic [4:0] flags_r;
    logic [7:0] rdata_r;
    logic mon_edge;
    logic clk_lost;
    logic cmp_req;
    logic wdt_tick;
    logic wdt_expire;
    logic above_top;
    logic pm_req;
    logic sw_req;
    logic hold_done;
    logic [4:0] req_vec;

    // monitored clock and comparator: two flops before any logic looks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mon_sync_r <= 3'h0;
            cmp_sync_r <= 2'h3;
        end
        else
        begin
            mon_sync_r <= {mon_sync_r[1:0], mon_clk_i};
            cmp_sync_r <= {cmp_sync_r[0], cmp_out_i};
        end
    end

    assign mon_edge = mon_sync_r[2] ^ mon_sync_r[1];

    // one-shot: each monitored edge retriggers, a stall past the limit fires
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !clk_loss_en_r || mon_edge)
        begin
            loss_cnt_r <= 32'h0;
        end
        else if (loss_cnt_r <= CLK_LOSS_LIMIT)
        begin
            loss_cnt_r <= loss_cnt_r + 32'h1;
        end
    end

    // strictly more than the limit; saturates until the clock moves again
    assign clk_lost = clk_loss_en_r && (loss_cnt_r > CLK_LOSS_LIMIT);

    // enables survive internal resets, only the power-on reset clears them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_loss_en_r <= 1'b0;
            cmp_arm_r <= 1'b0;
        end
        else if (link.src_wr && state_r == ST_RUN)
        begin
            clk_loss_en_r <= link.src_wdata[CLK_LOSS_BIT];
            cmp_arm_r <= link.src_wdata[CMP_RESET_BIT];
        end
    end

    // low comparator output means + below -, an active-low request
    assign cmp_req = cmp_arm_r && !cmp_sync_r[1];

    // divide by twelve enable for the watchdog
    always_ff @(posedge clk_i)
    begin
        if (rst_i || sys_reset_o || div_cnt_r == 4'(WDT_DIVIDE - 1))
        begin
            div_cnt_r <= 4'h0;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    assign wdt_tick = (div_cnt_r == 4'(WDT_DIVIDE - 1));

    // watchdog restarts from zero on every reset; the core end re-enables it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || sys_reset_o || link.wdt_kick || !link.wdt_enable)
        begin
            wdt_cnt_r <= 32'h0;
        end
        else if (wdt_tick)
        begin
            wdt_cnt_r <= wdt_cnt_r + 32'h1;
        end
    end

    assign wdt_expire = link.wdt_enable && wdt_tick && !link.wdt_kick
        && (wdt_cnt_r == WDT_TICKS - 1);

    // program memory checks; debug port accesses never reach a reset
    assign above_top = (link.acc_addr > CODE_TOP);
    always_comb
    begin
        pm_req = 1'b0;
        if (link.acc_valid && !link.acc_debug)
        begin
            if (link.acc_denied)
            begin
                pm_req = 1'b1;
            end
            else if (link.acc_kind == ACC_DATA_WRITE || link.acc_kind == ACC_ERASE)
            begin
                pm_req = above_top && link.program_store_write_enable;
            end
            else if (link.acc_kind == ACC_CODE_READ)
            begin
                pm_req = above_top;
            end
            else
            begin
                pm_req = above_top;
            end
        end
    end

    assign sw_req = link.src_wr && link.src_wdata[SW_RESET_BIT];

    // one bit per request, several may be set; the priority below picks a single cause
    assign req_vec = {sw_req, pm_req, wdt_expire, cmp_req, clk_lost};

    // clock loss and comparator are levels and keep the hold going
    assign hold_done = (hold_cnt_r >= RESET_HOLD_CYCLES - 1) && !clk_lost && !cmp_req;

    // reset sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_RUN;
            hold_cnt_r <= 32'h0;
            cause_r <= 5'h0;
        end
        else
        begin
            case (state_r)
                ST_RUN:
                begin
                    hold_cnt_r <= 32'h0;
                    if (req_vec != 5'h0)
                    begin
                        state_r <= ST_HOLD;
                        cause_r <= req_vec & (~req_vec + 5'h1);
                    end
                end
                ST_HOLD:
                begin
                    if (hold_done)
                    begin
                        state_r <= ST_RUN;
                    end
                    else if (hold_cnt_r < RESET_HOLD_CYCLES - 1)
                    begin
                        hold_cnt_r <= hold_cnt_r + 32'h1;
                    end
                end
                default:
                begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // flags take the cause as the reset ends, so only the latest shows
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_r <= 5'h0;
        end
        else if (state_r == ST_HOLD && hold_done)
        begin
            flags_r <= cause_r;
        end
    end

    // register image; watchdog and comparator share one bit position
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_r <= SRC_RESET_VALUE;
        end
        else
        begin
            rdata_r <= SRC_RESET_VALUE;
            rdata_r[CLK_LOSS_BIT] <= flags_r[CAUSE_CLK];
            rdata_r[SW_RESET_BIT] <= flags_r[CAUSE_SW];
            rdata_r[CMP_RESET_BIT] <= flags_r[CAUSE_CMP] | flags_r[CAUSE_WDT];
            rdata_r[PM_ERROR_BIT] <= flags_r[CAUSE_PM];
        end
    end

    assign link.src_rdata = rdata_r;
    assign sys_reset_o = (state_r == ST_HOLD);
    assign link.sys_reset = sys_reset_o;

    // the external reset pin is only ever an input for these sources
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = 1'b0;

endmodule // reset_source_controller

// [logic/reset_core_regs.sv]
// core-side end: classic wishbone slave that issues orders to the reset
// source controller and reads back its flags
// assumes the same clock as the controller; bus signals are synchronous
`timescale 1ns/100ps
module reset_core_regs
(
    input wire logic clk_i,
    input wire logic rst_i,
    rst_ctrl_if.core link,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o
);
    import reset_cause_pkg::*;

    logic ack_r;
    logic [31:0] dat_r;
    logic store_wr_r;
    logic wdt_en_r;
    logic src_wr_r;
    logic [7:0] src_wdata_r;
    logic kick_r;
    logic acc_valid_r;
    acc_kind_e acc_kind_r;
    logic [15:0] acc_addr_r;
    logic acc_denied_r;
    logic acc_debug_r;
    logic wr_take;

    // one wait state: ack the cycle after the strobe, then drop it
    assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // read mux; unmapped offsets read as zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_r <= 32'h0;
        end
        else if (wb_adr_i == ADR_SOURCE)
        begin
            dat_r <= {24'h0, link.src_rdata};
        end
        else if (wb_adr_i == ADR_CONTROL)
        begin
            dat_r <= {30'h0, wdt_en_r, store_wr_r};
        end
        else
        begin
            dat_r <= 32'h0;
        end
    end

    // control levels; a system reset restores them like power-on
    always_ff @(posedge clk_i)
    begin
        if (rst_i || link.sys_reset)
        begin
            store_wr_r <= STORE_WR_RESET_VALUE;
            wdt_en_r <= WDT_EN_RESET_VALUE;
        end
        else if (wr_take && wb_adr_i == ADR_CONTROL && wb_sel_i[0])
        begin
            store_wr_r <= wb_dat_i[CTL_STORE_WR_BIT];
            wdt_en_r <= wb_dat_i[CTL_WDT_EN_BIT];
        end
    end

    // one-cycle orders; write data is held for the access request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_wr_r <= 1'b0;
            src_wdata_r <= 8'h00;
            kick_r <= 1'b0;
            acc_valid_r <= 1'b0;
            acc_kind_r <= ACC_DATA_WRITE;
            acc_addr_r <= 16'h0000;
            acc_denied_r <= 1'b0;
            acc_debug_r <= 1'b0;
        end
        else
        begin
            src_wr_r <= wr_take && wb_adr_i == ADR_SOURCE && wb_sel_i[0];
            kick_r <= wr_take && wb_adr_i == ADR_KICK;
            acc_valid_r <= wr_take && wb_adr_i == ADR_ACCESS && wb_sel_i == 4'hf;
            if (wr_take)
            begin
                src_wdata_r <= wb_dat_i[7:0];
                acc_kind_r <= acc_kind_e'(wb_dat_i[ACC_KIND_LSB +: 2]);
                acc_addr_r <= wb_dat_i[15:0];
                acc_denied_r <= wb_dat_i[ACC_DENIED_BIT];
                acc_debug_r <= wb_dat_i[ACC_DEBUG_BIT];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign link.src_wr = src_wr_r;
    assign link.src_wdata = src_wdata_r;
    assign link.program_store_write_enable = store_wr_r;
    assign link.wdt_enable = wdt_en_r;
    assign link.wdt_kick = kick_r;
    assign link.acc_valid = acc_valid_r;
    assign link.acc_kind = acc_kind_r;
    assign link.acc_addr = acc_addr_r;
    assign link.acc_denied = acc_denied_r;
    assign link.acc_debug = acc_debug_r;

endmodule // reset_core_regs

// [dv/reset_link_props.sv]
// checker on the link between the core register end and the reset controller
// assumes one clock domain, synchronous active-high rst_i, the large variant
`timescale 1ns/100ps
module reset_link_props
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic src_wr,
    input wire logic [7:0] src_wdata,
    input wire logic [7:0] src_rdata,
    input wire logic sys_reset,
    input wire logic program_store_write_enable,
    input wire logic acc_valid,
    input wire reset_cause_pkg::acc_kind_e acc_kind,
    input wire logic [15:0] acc_addr,
    input wire logic acc_denied,
    input wire logic acc_debug
);
    import reset_cause_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // requests only count when no reset is already running
    wire sw_go = src_wr && src_wdata[SW_RESET_BIT] && !sys_reset;
    wire pm_high = acc_valid && !acc_debug && !sys_reset && acc_addr > CODE_TOP_LARGE;
    wire pm_deny = acc_valid && acc_denied && !acc_debug && !sys_reset;

    sequence hold4;
        sys_reset [*4];
    endsequence

    // exact hold, release, then the captured flag one cycle later
    sequence done(logic [7:0] f);
        hold4 ##1 !sys_reset ##1 src_rdata == f;
    endsequence

    AST_SW_RESET: assert property (sw_go |=> done(8'h10))
        else $error("software reset did not run its course");
    AST_HOLD_MIN: assert property ($rose(sys_reset) |-> hold4)
        else $error("system reset shorter than four cycles");
    AST_ONE_FLAG: assert property ($fell(sys_reset) |=> $onehot(src_rdata))
        else $error("not exactly one cause flag after reset");
    AST_FLAG_STABLE: assert property ($changed(src_rdata) |->
        !$past(sys_reset) && $past(sys_reset, 2))
        else $error("cause flags moved outside reset end");
    AST_PM_RANGE: assert property (
        pm_high && !acc_denied && acc_kind[1] |=> done(8'h40))
        else $error("read or fetch above code top not reset");
    AST_PM_WRITE: assert property (
        pm_high && program_store_write_enable && !acc_kind[1] |=> sys_reset)
        else $error("enabled write above code top not reset");
    AST_PM_DENIED: assert property (pm_deny |=> done(8'h40))
        else $error("forbidden access not reset");
    AST_DEBUG_QUIET: assert property (
        acc_valid && acc_debug && !sys_reset |=> !sys_reset)
        else $error("debug port access caused a reset");
endmodule // reset_link_props

// [dv/tb.sv]
// self-checking bench: core register end and reset controller on one link
// assumes 100 MHz clock; all bus traffic comes from the tasks below
`timescale 1ns/100ps
module tb;
    import reset_cause_pkg::*;

    // short watchdog span so the expiry run stays brief
    localparam int unsigned TB_WDT_TICKS = 40;

    typedef struct {logic [31:0] acc; logic store_wr; logic rst;} row_s;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic mon_clk_i = 1'b0;
    logic mon_run = 1'b1;
    logic cmp_out_i = 1'b1;
    logic pin_bad = 1'b0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o;
    logic rst_pin_o;
    logic rst_pin_oe_o;
    logic sys_reset_o;
    logic sr_q;
    int rst_cnt = 0;
    int miscompares = 0;
    int cmp_count = 0;
    int c0;
    // access word: debug[19] denied[18] kind[17:16] addr; store write; reset expected
    row_s rows [9] = '{
        '{32'h0003_3dff, 1'b0, 1'b0}, '{32'h0003_3e00, 1'b0, 1'b1},
        '{32'h0002_3e00, 1'b0, 1'b1}, '{32'h0002_3dff, 1'b0, 1'b0},
        '{32'h0000_3e00, 1'b0, 1'b0}, '{32'h0000_3e00, 1'b1, 1'b1},
        '{32'h0001_3e00, 1'b1, 1'b1}, '{32'h0006_0100, 1'b0, 1'b1},
        '{32'h000f_3e00, 1'b0, 1'b0}};

    rst_ctrl_if lnk();

    reset_core_regs i_reset_core_regs (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(4'hf), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

    // short limits keep clock-loss and watchdog runs brief
    reset_source_controller #(.CLK_LOSS_LIMIT(50), .WDT_TICKS(TB_WDT_TICKS), .LARGE_VARIANT(1'b1))
        i_reset_source_controller (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
        .mon_clk_i(mon_clk_i), .cmp_out_i(cmp_out_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_o(rst_pin_oe_o), .sys_reset_o(sys_reset_o));

    reset_link_props i_reset_link_props (.clk_i(clk_i), .rst_i(rst_i),
        .src_wr(lnk.src_wr), .src_wdata(lnk.src_wdata), .src_rdata(lnk.src_rdata),
        .sys_reset(lnk.sys_reset),
        .program_store_write_enable(lnk.program_store_write_enable),
        .acc_valid(lnk.acc_valid),
        .acc_kind(lnk.acc_kind), .acc_addr(lnk.acc_addr), .acc_denied(lnk.acc_denied),
        .acc_debug(lnk.acc_debug));

    always #5 clk_i = ~clk_i;

    // monitored clock at half rate; a test stalls it to fake a lost clock
    always @(posedge clk_i) mon_clk_i <= mon_run ? ~mon_clk_i : mon_clk_i;

    // count reset entries; the pin must never be driven by any cause
    always @(posedge clk_i)
    begin
        sr_q <= sys_reset_o;
        if (sys_reset_o === 1'b1 && sr_q !== 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (rst_pin_oe_o !== 1'b0 || rst_pin_o !== 1'b0)
            pin_bad <= 1'b1;
    end

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // classic single cycle; no fixed latency assumed, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        chk_flag(wb_ack_o, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic idle();
        int n;
        n = 0;
        while (sys_reset_o !== 1'b0 && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (4) @(posedge clk_i);
    endtask

    // kick, issue one write, see whether a reset follows and which flag it left
    task automatic run(input logic [7:0] a, input logic [31:0] d, input logic e,
        input logic [31:0] f);
        int s;
        wb(1'b1, ADR_KICK, 32'h0);
        s = rst_cnt;
        wb(1'b1, a, d);
        repeat (8) @(posedge clk_i);
        chk_flag(rst_cnt != s, e);
        idle();
        if (e)
        begin
            wb(1'b0, ADR_SOURCE, 32'h0);
            chk_val(q, f);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, ADR_SOURCE, 32'h0);
        chk_val(q, 32'h0);
        wb(1'b0, ADR_CONTROL, 32'h0);
        chk_val(q, 32'h2);
        $display("end reset values");
        foreach (rows[i])
        begin
            wb(1'b1, ADR_CONTROL, {30'h0, 1'b1, rows[i].store_wr});
            run(ADR_ACCESS, rows[i].acc, rows[i].rst, 32'h40);
        end
        $display("end access table");
        // store write on, watchdog off: the reset must restore both
        wb(1'b1, ADR_CONTROL, 32'h1);
        run(ADR_SOURCE, 32'h10, 1'b1, 32'h10);
        wb(1'b0, ADR_CONTROL, 32'h0);
        chk_val(q, 32'h2);
        $display("end software reset");
        run(ADR_SOURCE, 32'h20, 1'b0, 32'h0);
        cmp_out_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk_flag(sys_reset_o, 1'b1);
        cmp_out_i <= 1'b1;
        idle();
        wb(1'b0, ADR_SOURCE, 32'h0);
        chk_val(q, 32'h20);
        run(ADR_SOURCE, 32'h0, 1'b0, 32'h0);
        // disarmed: a low comparator must no longer reset
        cmp_out_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk_flag(sys_reset_o, 1'b0);
        cmp_out_i <= 1'b1;
        $display("end comparator");
        run(ADR_SOURCE, 32'h04, 1'b0, 32'h0);
        mon_run <= 1'b0;
        repeat (45) @(posedge clk_i);
        chk_flag(sys_reset_o, 1'b0);
        repeat (35) @(posedge clk_i);
        chk_flag(sys_reset_o, 1'b1);
        mon_run <= 1'b1;
        idle();
        wb(1'b0, ADR_SOURCE, 32'h0);
        chk_val(q, 32'h04);
        run(ADR_SOURCE, 32'h0, 1'b0, 32'h0);
        mon_run <= 1'b0;
        repeat (80) @(posedge clk_i);
        chk_flag(sys_reset_o, 1'b0);
        mon_run <= 1'b1;
        $display("end clock loss");
        // expiry lands within one divide period of ticks times twelve
        wb(1'b1, ADR_KICK, 32'h0);
        c0 = 0;
        while (sys_reset_o !== 1'b1 && c0 < 800)
        begin
            @(posedge clk_i);
            c0++;
        end
        c0 = c0 - WDT_DIVIDE * (TB_WDT_TICKS - 1);
        chk_flag(c0 > 0 && c0 <= WDT_DIVIDE, 1'b1);
        idle();
        wb(1'b0, ADR_SOURCE, 32'h0);
        chk_val(q, 32'h20);
        wb(1'b0, 8'h20, 32'h0);
        chk_val(q, 32'h0);
        chk_flag(pin_bad, 1'b0);
        $display("end watchdog");
        report_and_stop();
    end
endmodule // tb
